//--- rtl/ccv_pkg.sv
// package with register map, field layout and code-to-value mapping constants
package ccv_pkg;

  // register offsets on the serial subaddress
  localparam logic [7:0] ADDR_CHARGE_CURRENT_CONFIG = 8'h01;
  localparam logic [7:0] ADDR_INPUT_LIMIT_VOLTAGE_CONFIG = 8'h02;
  localparam logic [7:0] ADDR_SAFETY_LIMIT = 8'h04;

  // reset values
  localparam logic [7:0] RST_CHARGE_CURRENT_CONFIG = 8'h01;
  localparam logic [7:0] RST_INPUT_LIMIT_VOLTAGE_CONFIG = 8'h19;
  localparam logic [7:0] RST_SAFETY_LIMIT = 8'h40;

  // default 7-bit serial device address (group 1101, device 010)
  localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h6a;

  // field positions of charge_current_config
  localparam int LIMIT_SOURCE_SELECT_BIT = 7;
  localparam int FAST_CHARGE_CURRENT_LSB = 3;
  localparam int TERMINATION_CURRENT_LSB = 0;
  // field positions of input_limit_voltage_config
  localparam int INPUT_LIMIT_LSB = 6;
  localparam int REGULATION_VOLTAGE_LSB = 0;
  // field positions of the safety-limit register
  localparam int SAFETY_MAX_CURRENT_LSB = 4;
  localparam int SAFETY_MAX_VOLTAGE_LSB = 0;

  // fast-charge sense voltage: base, step, saturating code
  localparam logic [4:0] FAST_BASE_MV = 5'h0b;
  localparam logic [4:0] FAST_STEP_MV = 5'h02;
  localparam logic [3:0] FAST_MAX_CODE = 4'ha;
  // termination sense voltage: base and step
  localparam logic [3:0] TERM_BASE_MV = 4'h1;
  localparam logic [3:0] TERM_STEP_MV = 4'h1;
  // battery regulation voltage: base, step, saturating code
  localparam logic [12:0] VREG_BASE_MV = 13'hdac;
  localparam logic [12:0] VREG_STEP_MV = 13'h014;
  localparam logic [5:0] VREG_MAX_CODE = 6'h2f;
  // safety maximum regulation voltage: base, step, saturating code
  localparam logic [12:0] SAFE_V_BASE_MV = 13'h1068;
  localparam logic [12:0] SAFE_V_STEP_MV = 13'h014;
  localparam logic [3:0] SAFE_V_MAX_CODE = 4'hc;
  // boost output: code giving 5 V, saturating code giving 5.5 V
  localparam logic [5:0] BOOST_5V_CODE = 6'h19;
  localparam logic [5:0] BOOST_MAX_CODE = 6'h2f;
  // input limit code meaning no limit
  localparam logic [1:0] INPUT_LIMIT_NONE = 2'h3;

  // effective regulation targets handed to the analog side
  typedef struct packed {
    logic [1:0] input_limit_code;
    logic input_limit_off;
    logic [4:0] fast_charge_mv;
    logic [3:0] termination_mv;
    logic [12:0] regulation_mv;
    logic [5:0] boost_voltage_code;
    logic boost_at_least_5v;
  } ccv_targets_s;

endpackage : ccv_pkg

//--- rtl/ccv_limit_derive.sv
// derivation of effective charge targets from programmed and safety codes
`timescale 1ns/1ps
module ccv_limit_derive (
  input wire logic [7:0] charge_current_config,
  input wire logic [7:0] input_limit_voltage_config,
  input wire logic [7:0] safety_limit,
  input wire logic [1:0] dpdm_result,
  input wire logic charging,
  output ccv_pkg::ccv_targets_s targets
);

  // field extraction
  wire limit_source_select = charge_current_config[ccv_pkg::LIMIT_SOURCE_SELECT_BIT];
  wire [3:0] fast_charge_current_code =
    charge_current_config[ccv_pkg::FAST_CHARGE_CURRENT_LSB +: 4];
  wire [2:0] termination_current_code =
    charge_current_config[ccv_pkg::TERMINATION_CURRENT_LSB +: 3];
  wire [1:0] input_limit_code = input_limit_voltage_config[ccv_pkg::INPUT_LIMIT_LSB +: 2];
  wire [5:0] regulation_voltage_code =
    input_limit_voltage_config[ccv_pkg::REGULATION_VOLTAGE_LSB +: 6];
  wire [3:0] safety_max_current_code = safety_limit[ccv_pkg::SAFETY_MAX_CURRENT_LSB +: 4];
  wire [3:0] safety_max_voltage_code = safety_limit[ccv_pkg::SAFETY_MAX_VOLTAGE_LSB +: 4];

  // input limit: codes are ordered so that the higher code is the higher limit
  wire [1:0] eff_input_limit = limit_source_select ? input_limit_code :
    ((dpdm_result > input_limit_code) ? dpdm_result : input_limit_code);

  // saturate codes beyond the top of their tables
  wire [3:0] fast_sat = (fast_charge_current_code > ccv_pkg::FAST_MAX_CODE) ?
    ccv_pkg::FAST_MAX_CODE : fast_charge_current_code;
  wire [3:0] safe_i_sat = (safety_max_current_code > ccv_pkg::FAST_MAX_CODE) ?
    ccv_pkg::FAST_MAX_CODE : safety_max_current_code;
  wire [5:0] vreg_sat = (regulation_voltage_code > ccv_pkg::VREG_MAX_CODE) ?
    ccv_pkg::VREG_MAX_CODE : regulation_voltage_code;
  wire [3:0] safe_v_sat = (safety_max_voltage_code > ccv_pkg::SAFE_V_MAX_CODE) ?
    ccv_pkg::SAFE_V_MAX_CODE : safety_max_voltage_code;
  wire [5:0] boost_sat = (regulation_voltage_code > ccv_pkg::BOOST_MAX_CODE) ?
    ccv_pkg::BOOST_MAX_CODE : regulation_voltage_code;

  // both current tables share one scale, so the lower code is the lower current
  wire [3:0] eff_fast = (charging && (safe_i_sat < fast_sat)) ? safe_i_sat : fast_sat;

  // voltages compared in millivolts since the two tables start at different bases
  wire [12:0] vreg_mv = 13'(ccv_pkg::VREG_BASE_MV + 13'(vreg_sat) * ccv_pkg::VREG_STEP_MV);
  wire [12:0] safe_v_mv =
    13'(ccv_pkg::SAFE_V_BASE_MV + 13'(safe_v_sat) * ccv_pkg::SAFE_V_STEP_MV);
  wire [12:0] eff_vreg_mv = (charging && (safe_v_mv < vreg_mv)) ? safe_v_mv : vreg_mv;

  // pack the targets
  assign targets.input_limit_code = eff_input_limit;
  assign targets.input_limit_off = (eff_input_limit == ccv_pkg::INPUT_LIMIT_NONE);
  assign targets.fast_charge_mv =
    5'(ccv_pkg::FAST_BASE_MV + 5'(eff_fast) * ccv_pkg::FAST_STEP_MV);
  assign targets.termination_mv =
    4'(ccv_pkg::TERM_BASE_MV + 4'(termination_current_code) * ccv_pkg::TERM_STEP_MV);
  assign targets.regulation_mv = eff_vreg_mv;
  assign targets.boost_voltage_code = boost_sat;
  assign targets.boost_at_least_5v = (boost_sat >= ccv_pkg::BOOST_5V_CODE);

endmodule : ccv_limit_derive

//--- rtl/ccv_top.sv
// charger current/voltage configuration bank behind a serial two-wire slave
//
// Overview of operation
// - select bit 0: input limit is the higher of programmed code and detection.
// - select bit 1: only the programmed input limit code applies.
// - fast-charge code gives 11 mV plus 2 mV per step, saturating 31 mV.
// - input limit codes 100, 500, 975 mA; code 11 removes the limit.
// - voltage code gives 3.50 V plus 20 mV per step, saturating 4.44 V.
// - in boost the voltage code sets output; 011001 is 5 V, saturating 5.5 V.
// - while charging, current follows the lower of programmed and safety codes.
// - while charging, voltage follows the lower of programmed and safety values.
// - safety register writable only until a write to any offset other than its own after reset.
`timescale 1ns/1ps
module ccv_top #(
  parameter logic [6:0] DEV_ADDR = ccv_pkg::DEV_ADDR_DEFAULT
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic [1:0] dpdm_result,
  input wire logic charging,
  output logic safety_locked,
  output ccv_pkg::ccv_targets_s targets
);

  // elaboration check: an all-zero address is the general call and cannot be served
  if (DEV_ADDR == 7'h00) begin : g_addr_check
    $error("device address must not be the general call address");
  end

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_ADDR = 4'h1,
    ST_ADDR_ACK = 4'h3,
    ST_SUB = 4'h2,
    ST_SUB_ACK = 4'h6,
    ST_WDATA = 4'h7,
    ST_WDATA_ACK = 4'h5,
    ST_RDATA = 4'h4,
    ST_RDATA_ACK = 4'hc
  } ccv_state_e;

  ccv_state_e state;
  logic scl_m, scl_s, scl_d;
  logic sda_m, sda_s, sda_d;
  logic [7:0] shift;
  logic [2:0] bit_cnt;
  logic rw_read;
  logic master_nack;
  logic ack_drive;
  logic [7:0] ptr;
  logic wr_en;
  logic [7:0] wr_data;
  logic [7:0] charge_current_config;
  logic [7:0] input_limit_voltage_config;
  logic [7:0] safety_limit;
  logic safety_lock;
  logic [7:0] rd_byte;

  // two-stage synchronisers, then one delay stage for edge detection
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      scl_m <= 1'b1;
      scl_s <= 1'b1;
      scl_d <= 1'b1;
      sda_m <= 1'b1;
      sda_s <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_m <= scl_in;
      scl_s <= scl_m;
      scl_d <= scl_s;
      sda_m <= sda_in;
      sda_s <= sda_m;
      sda_d <= sda_s;
    end
  end

  // bus events, all taken from the synchronised copies only
  wire scl_rise = scl_s & ~scl_d;
  wire scl_fall = ~scl_s & scl_d;
  wire bus_start = scl_s & scl_d & sda_d & ~sda_s;
  wire bus_stop = scl_s & scl_d & ~sda_d & sda_s;
  wire last_bit = (bit_cnt == 3'h7);
  wire [7:0] rx_byte = {shift[6:0], sda_s};
  wire addr_match = (shift[6:0] == DEV_ADDR);
  wire [7:0] ptr_next = 8'(ptr + 8'h01);

  // read data selection; unmapped offsets read as zero
  assign rd_byte =
    (ptr == ccv_pkg::ADDR_CHARGE_CURRENT_CONFIG) ? charge_current_config :
    (ptr == ccv_pkg::ADDR_INPUT_LIMIT_VOLTAGE_CONFIG) ? input_limit_voltage_config :
    (ptr == ccv_pkg::ADDR_SAFETY_LIMIT) ? safety_limit : 8'h00;

  // serial protocol engine; the ack is driven from the falling edge after bit 8
  // so that the line never changes while the clock is high
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state <= ST_IDLE;
      shift <= 8'h00;
      bit_cnt <= 3'h0;
      rw_read <= 1'b0;
      master_nack <= 1'b0;
      ack_drive <= 1'b0;
      ptr <= 8'h00;
      wr_en <= 1'b0;
      wr_data <= 8'h00;
    end else begin
      wr_en <= 1'b0;
      if (bus_start) begin
        state <= ST_ADDR;
        bit_cnt <= 3'h0;
        ack_drive <= 1'b0;
      end else if (bus_stop) begin
        state <= ST_IDLE;
        ack_drive <= 1'b0;
      end else begin
        case (state)
          ST_ADDR: begin
            if (scl_rise) begin
              shift <= rx_byte;
              bit_cnt <= 3'(bit_cnt + 3'h1);
              if (last_bit) begin
                rw_read <= sda_s;
                state <= addr_match ? ST_ADDR_ACK : ST_IDLE;
              end
            end
          end
          ST_ADDR_ACK: begin
            if (scl_fall) begin
              if (!ack_drive) begin
                ack_drive <= 1'b1;
              end else if (rw_read) begin
                shift <= rd_byte;
                ack_drive <= ~rd_byte[7];
                bit_cnt <= 3'h0;
                state <= ST_RDATA;
              end else begin
                ack_drive <= 1'b0;
                bit_cnt <= 3'h0;
                state <= ST_SUB;
              end
            end
          end
          ST_SUB: begin
            if (scl_rise) begin
              shift <= rx_byte;
              bit_cnt <= 3'(bit_cnt + 3'h1);
              if (last_bit) begin
                ptr <= rx_byte;
                state <= ST_SUB_ACK;
              end
            end
          end
          ST_SUB_ACK, ST_WDATA_ACK: begin
            if (scl_fall) begin
              if (!ack_drive) begin
                ack_drive <= 1'b1;
              end else begin
                ack_drive <= 1'b0;
                bit_cnt <= 3'h0;
                if (state == ST_WDATA_ACK) begin
                  ptr <= ptr_next; // auto-increment after each data byte
                end
                state <= ST_WDATA;
              end
            end
          end
          ST_WDATA: begin
            if (scl_rise) begin
              shift <= rx_byte;
              bit_cnt <= 3'(bit_cnt + 3'h1);
              if (last_bit) begin
                wr_en <= 1'b1;
                wr_data <= rx_byte;
                state <= ST_WDATA_ACK;
              end
            end
          end
          ST_RDATA: begin
            if (scl_fall) begin
              if (last_bit) begin
                ack_drive <= 1'b0; // release for the master's ack
                state <= ST_RDATA_ACK;
              end else begin
                ack_drive <= ~shift[6];
                shift <= {shift[6:0], 1'b0};
                bit_cnt <= 3'(bit_cnt + 3'h1);
              end
            end
          end
          ST_RDATA_ACK: begin
            if (scl_rise) begin
              master_nack <= sda_s;
              if (!sda_s) begin
                ptr <= ptr_next;
              end
            end else if (scl_fall) begin
              if (master_nack) begin
                state <= ST_IDLE;
              end else begin
                shift <= rd_byte;
                ack_drive <= ~rd_byte[7];
                bit_cnt <= 3'h0;
                state <= ST_RDATA;
              end
            end
          end
          default: begin
            state <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // write decode
  wire wr_charge = wr_en && (ptr == ccv_pkg::ADDR_CHARGE_CURRENT_CONFIG);
  wire wr_limit = wr_en && (ptr == ccv_pkg::ADDR_INPUT_LIMIT_VOLTAGE_CONFIG);
  wire wr_safety = wr_en && (ptr == ccv_pkg::ADDR_SAFETY_LIMIT) && !safety_lock;
  wire wr_other = wr_en && (ptr != ccv_pkg::ADDR_SAFETY_LIMIT);

  // configuration registers; reads have no side effects
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      charge_current_config <= ccv_pkg::RST_CHARGE_CURRENT_CONFIG;
      input_limit_voltage_config <= ccv_pkg::RST_INPUT_LIMIT_VOLTAGE_CONFIG;
      safety_limit <= ccv_pkg::RST_SAFETY_LIMIT;
      safety_lock <= 1'b0;
    end else begin
      if (wr_charge) begin
        charge_current_config <= wr_data;
      end
      if (wr_limit) begin
        input_limit_voltage_config <= wr_data;
      end
      if (wr_safety) begin
        safety_limit <= wr_data;
      end
      if (wr_other) begin
        safety_lock <= 1'b1;
      end
    end
  end

  // open-drain data line: only ever pulled low
  assign sda_out = 1'b0;
  assign sda_oe = ack_drive;
  assign safety_locked = safety_lock;

  // effective targets for the regulation loops
  ccv_limit_derive u_derive (
    .charge_current_config(charge_current_config),
    .input_limit_voltage_config(input_limit_voltage_config),
    .safety_limit(safety_limit),
    .dpdm_result(dpdm_result),
    .charging(charging),
    .targets(targets)
  );

endmodule : ccv_top

//--- tb/ccv_top_properties.sv
// concurrent checks on the configuration bank ports
`timescale 1ns/1ps
module ccv_top_properties (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic [1:0] dpdm_result,
  input wire logic charging,
  input wire logic safety_locked,
  input wire ccv_pkg::ccv_targets_s targets
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // open drain: the pull-up alone makes the high level
  sda_zero_a: assert property (sda_out == 1'b0)
    else $error("sda_out not low");
  // moving sda while scl is high would read as a false start or stop
  oe_scl_low_a: assert property ($changed(sda_oe) |-> !scl_in && !$past(scl_in))
    else $error("sda_oe changed near scl high");
  lock_hold_a: assert property (safety_locked |=> safety_locked)
    else $error("safety lock dropped");
  fast_range_a: assert property (targets.fast_charge_mv >= 5'h0b &&
    targets.fast_charge_mv[0])
    else $error("fast charge sense voltage off grid");
  term_range_a: assert property (targets.termination_mv inside {[4'h1:4'h8]})
    else $error("termination sense voltage out of range");
  vreg_range_a: assert property (targets.regulation_mv inside {[13'hdac:13'h1158]} &&
    (targets.regulation_mv - 13'hdac) % 13'h014 == 13'h000)
    else $error("regulation voltage off grid");
  boost_sat_a: assert property (targets.boost_voltage_code <= 6'h2f &&
    targets.boost_at_least_5v == (targets.boost_voltage_code >= 6'h19))
    else $error("boost code or flag wrong");
  limit_off_a: assert property (targets.input_limit_off ==
    (targets.input_limit_code == 2'h3))
    else $error("input limit off flag wrong");
  // starting a charge can only lower the targets, since the safety limits take the minimum
  charge_cap_a: assert property ($rose(charging) |->
    targets.fast_charge_mv <= $past(targets.fast_charge_mv) &&
    targets.regulation_mv <= $past(targets.regulation_mv))
    else $error("charging raised a target");
  cover property ($rose(safety_locked));
  cover property ($rose(sda_oe));
  cover property (charging && targets.input_limit_off);
endmodule : ccv_top_properties

bind ccv_top ccv_top_properties i_ccv_top_properties (
  .clk_sys(clk_sys), .rst(rst), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe(sda_oe), .dpdm_result(dpdm_result), .charging(charging),
  .safety_locked(safety_locked), .targets(targets)
);

//--- tb/ccv_host_model.sv
// host-side two-wire bus master that programs the configuration bank
`timescale 1ns/1ps
module ccv_host_model (
  input wire logic clk_sys,
  input wire logic sda,
  output logic scl,
  output logic sda_m,
  output logic nak
);
  int half_clk = 8; // scl phase length in clocks, at least 4
  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
    nak = 1'b0;
  end
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : wait_clk
  // sda moves two clocks after scl falls so the two never change together
  task automatic bit_io(input logic b, output logic r);
    wait_clk(2);
    sda_m <= b;
    wait_clk(half_clk);
    scl <= 1'b1;
    wait_clk(half_clk);
    r = sda;
    scl <= 1'b0;
  endtask : bit_io
  // eight bits msb first, then the ack slot with sda released
  task automatic xbyte(input logic [7:0] b, input logic want_ack, output logic [7:0] r);
    logic a;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], r[i]);
    end
    bit_io(1'b1, a);
    if (want_ack && a) begin
      nak = 1'b1;
    end
  endtask : xbyte
  task automatic start();
    wait_clk(2);
    sda_m <= 1'b1;
    wait_clk(half_clk);
    scl <= 1'b1;
    wait_clk(half_clk);
    sda_m <= 1'b0;
    wait_clk(half_clk);
    scl <= 1'b0;
  endtask : start
  task automatic stop();
    wait_clk(2);
    sda_m <= 1'b0;
    wait_clk(half_clk);
    scl <= 1'b1;
    wait_clk(half_clk);
    sda_m <= 1'b1;
    wait_clk(half_clk);
  endtask : stop
  task automatic write(input logic [7:0] sub, input logic [7:0] d);
    logic [7:0] r;
    start();
    xbyte({ccv_pkg::DEV_ADDR_DEFAULT, 1'b0}, 1'b1, r);
    xbyte(sub, 1'b1, r);
    xbyte(d, 1'b1, r);
    stop();
  endtask : write
  // the final data byte is answered with a nack to end the read
  task automatic read(input logic [7:0] sub, output logic [7:0] d);
    logic [7:0] r;
    start();
    xbyte({ccv_pkg::DEV_ADDR_DEFAULT, 1'b0}, 1'b1, r);
    xbyte(sub, 1'b1, r);
    start();
    xbyte({ccv_pkg::DEV_ADDR_DEFAULT, 1'b1}, 1'b1, r);
    xbyte(8'hff, 1'b0, d);
    stop();
  endtask : read
endmodule : ccv_host_model

//--- tb/ccv_top_tb_top.sv
// self-checking bench for the charger configuration bank
`timescale 1ns/1ps
module ccv_top_tb_top;
  logic clk_sys;
  logic rst;
  logic scl;
  logic sda_m;
  logic sda_oe;
  logic nak;
  logic [1:0] dpdm_result;
  logic charging;
  logic safety_locked;
  ccv_pkg::ccv_targets_s targets;
  logic [15:0] seed;
  logic [7:0] sfty;
  logic [7:0] rd;
  int fail_count;
  int total_checks;
  wire logic sda = sda_oe ? 1'b0 : sda_m; // pull-up and master release
  ccv_top i_ccv_top (.clk_sys(clk_sys), .rst(rst), .scl_in(scl), .sda_in(sda), .sda_out(),
    .sda_oe(sda_oe), .dpdm_result(dpdm_result), .charging(charging),
    .safety_locked(safety_locked), .targets(targets));
  ccv_host_model i_ccv_host_model (.clk_sys(clk_sys), .sda(sda), .scl(scl), .sda_m(sda_m),
    .nak(nak));
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  function automatic ccv_pkg::ccv_targets_s expect_t(input logic [7:0] a, input logic [7:0] b,
      input logic [1:0] dp, input logic chg, input logic [7:0] sf);
    ccv_pkg::ccv_targets_s t;
    logic [3:0] fc;
    logic [3:0] sc;
    logic [5:0] vc;
    logic [12:0] sv;
    fc = (a[6:3] > 4'ha) ? 4'ha : a[6:3];
    sc = (sf[7:4] > 4'ha) ? 4'ha : sf[7:4];
    vc = (b[5:0] > 6'h2f) ? 6'h2f : b[5:0];
    sv = 13'h1068 + 13'h014 * ((sf[3:0] > 4'hc) ? 13'h00c : {9'h000, sf[3:0]});
    t.input_limit_code = (a[7] || b[7:6] > dp) ? b[7:6] : dp;
    t.input_limit_off = (t.input_limit_code == 2'h3);
    if (chg && sc < fc) fc = sc;
    t.fast_charge_mv = 5'h0b + {fc, 1'b0};
    t.termination_mv = {1'b0, a[2:0]} + 4'h1;
    t.regulation_mv = 13'hdac + 13'h014 * {7'h00, vc};
    if (chg && sv < t.regulation_mv) t.regulation_mv = sv;
    t.boost_voltage_code = vc;
    t.boost_at_least_5v = (vc >= 6'h19);
    return t;
  endfunction : expect_t
  task automatic chk_b(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_b
  task automatic chk_t(input ccv_pkg::ccv_targets_s got, input ccv_pkg::ccv_targets_s exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_t
  task automatic end_sim();
    if (fail_count == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_sim
  // program both registers, read them back, then present detector and charge state
  task automatic apply(input logic [7:0] a, input logic [7:0] b, input logic [1:0] dp,
      input logic chg);
    i_ccv_host_model.write(8'h01, a);
    i_ccv_host_model.write(8'h02, b);
    i_ccv_host_model.read(8'h01, rd);
    chk_b(rd, a);
    i_ccv_host_model.read(8'h02, rd);
    chk_b(rd, b);
    chk_b({7'h00, nak}, 8'h00);
    dpdm_result <= dp;
    charging <= chg;
    repeat (2) @(negedge clk_sys);
    chk_t(targets, expect_t(a, b, dp, chg, sfty));
  endtask : apply
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  // bound on the whole run in case the bus hangs
  initial begin
    repeat (90000) @(posedge clk_sys);
    fail_count++;
    end_sim();
  end
  initial begin
    rst = 1'b1;
    dpdm_result = 2'h0;
    charging = 1'b0;
    fail_count = 0;
    total_checks = 0;
    seed = 16'h0030;
    sfty = 8'h21;
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (4) @(negedge clk_sys);
    chk_t(targets, expect_t(8'h01, 8'h19, 2'h0, 1'b0, 8'h40));
    i_ccv_host_model.write(8'h04, sfty);
    i_ccv_host_model.read(8'h01, rd);
    chk_b(rd, 8'h01);
    i_ccv_host_model.read(8'h02, rd);
    chk_b(rd, 8'h19);
    i_ccv_host_model.read(8'h07, rd);
    chk_b(rd, 8'h00);
    chk_b({7'h00, safety_locked}, 8'h00);
    apply(8'hff, 8'hff, 2'h0, 1'b0);
    chk_b({7'h00, safety_locked}, 8'h01);
    i_ccv_host_model.write(8'h04, 8'h00); // locked, so ignored
    i_ccv_host_model.read(8'h04, rd);
    chk_b(rd, sfty);
    apply(8'h50, 8'h2f, 2'h1, 1'b1);
    apply(8'h00, 8'h40, 2'h2, 1'b1);
    apply(8'h78, 8'h99, 2'h3, 1'b0);
    // detector above the programmed code must be ignored when the select bit is set
    apply(8'h80, 8'h00, 2'h3, 1'b0);
    // random settings with fast and slow bus phases
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      rd = seed[7:0];
      seed = lfsr(seed);
      i_ccv_host_model.half_clk = seed[11] ? 12 : 6;
      apply(rd, seed[7:0], seed[9:8], seed[10]);
    end
    // a second reset restores defaults and clears the lock; the bus is idle here
    @(posedge clk_sys);
    rst <= 1'b1;
    dpdm_result <= 2'h0;
    charging <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (4) @(negedge clk_sys);
    chk_t(targets, expect_t(8'h01, 8'h19, 2'h0, 1'b0, 8'h40));
    chk_b({7'h00, safety_locked}, 8'h00);
    i_ccv_host_model.read(8'h04, rd);
    chk_b(rd, 8'h40);
    i_ccv_host_model.read(8'h01, rd);
    chk_b(rd, 8'h01);
    end_sim();
  end
endmodule : ccv_top_tb_top
